// ### logic/slave_err_pkg.sv
package slave_err_pkg;

  // controller family that decides where the status area sits
  typedef enum logic [0:0] {
    FAM_NEW = 1'b0,
    FAM_OLD = 1'b1
  } host_family_t;

  // static configuration of the master
  typedef struct packed {
    host_family_t fam;
    logic         mode32;
    logic [3:0]   unit;
  } cfg_t;

  // one bit per slave, outputs in the upper half
  typedef struct packed {
    logic [15:0] outs;
    logic [15:0] ins;
  } slave_vec_t;

  // result of the first-error search
  typedef struct packed {
    logic       found;
    logic       dir;
    logic [3:0] node;
  } pick_t;

  // whole state of the reporting block
  typedef struct packed {
    slave_vec_t  act;
    slave_vec_t  err;
    logic        disp_v;
    logic        disp_dir;
    logic [3:0]  disp_node;
    logic [15:0] first_word;
    logic        unit_bad;
    logic [15:0] rd_data;
    logic        rd_hit;
  } state_t;

endpackage

// ### logic/slave_err_regs.svh
`ifndef SLAVE_ERR_REGS_SVH
`define SLAVE_ERR_REGS_SVH

// status area base for the newer controller family
`define BASE_NEW        16'h07D0
// status area bases for the older controller family
`define BASE_OLD_LOW    16'h0064
`define BASE_OLD_HIGH   16'h0190
// words reserved per unit number
`define WORDS_PER_UNIT  16'h000A
// first unit number served by the high base
`define UNIT_HIGH_FIRST 4'hA
// unit numbers refused by the old family in the 32-slave setting
`define UNIT_BAD_A      4'h9
`define UNIT_BAD_B      4'hF

// word offsets from the first word of the status area
`define OFS_OUT_16      16'h0000
`define OFS_IN_16       16'h0009
`define OFS_OUT_LO_32   16'h0010
`define OFS_IN_LO_32    16'h0011
`define OFS_OUT_HI_32   16'h0012
`define OFS_IN_HI_32    16'h0013

// slave masks: the 16 setting only serves nodes 0 to 7
`define MASK_16         16'h00FF
`define MASK_32         16'hFFFF

// status word field positions
`define ERR_MSB         15
`define ERR_LSB         8
`define ACT_MSB         7
`define ACT_LSB         0

// reset value of every status word
`define STATUS_RESET    16'h0000

`endif

// ### logic/slave_error_node_display.sv
`timescale 1ns/1ps
`include "slave_err_regs.svh"
module slave_error_node_display (
  // clock and reset
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst_n,
  // configuration and restart
  input  wire slave_err_pkg::cfg_t        i_cfg,
  input  wire logic                       i_restart,
  // slave network events, one-cycle pulses per slave
  input  wire slave_err_pkg::slave_vec_t  i_join,
  input  wire slave_err_pkg::slave_vec_t  i_fail,
  input  wire slave_err_pkg::slave_vec_t  i_ok,
  // controller memory read port
  input  wire logic                       i_rd_en,
  input  wire logic [15:0]                i_rd_addr,
  output logic [15:0]                     o_rd_data,
  output logic                            o_rd_hit,
  // status area placement
  output logic [15:0]                     o_first_word,
  output logic                            o_unit_bad,
  // indicators
  output logic                            o_comm_error_indicator,
  output logic                            o_dir_indicator,
  output logic [3:0]                      o_node_ind
);

  slave_err_pkg::state_t     st_q;
  slave_err_pkg::state_t     st_d;
  slave_err_pkg::slave_vec_t join_m;
  slave_err_pkg::slave_vec_t fail_m;
  slave_err_pkg::slave_vec_t ok_m;
  slave_err_pkg::pick_t      pick;
  slave_err_pkg::slave_vec_t live_err;
  logic [15:0]               mask;
  logic [15:0]               ofs;
  logic                      release_disp;

  // start of the status area for the given configuration
  function automatic logic [15:0] first_word_of(input slave_err_pkg::cfg_t c);
    logic [15:0] u;
    logic [31:0] prod;
    u = {12'h000, c.unit};
    if (c.fam == slave_err_pkg::FAM_NEW) begin
      prod = 32'(u) * 32'(`WORDS_PER_UNIT);
      first_word_of = `BASE_NEW + prod[15:0];
    end else if (c.unit < `UNIT_HIGH_FIRST) begin
      prod = 32'(u) * 32'(`WORDS_PER_UNIT);
      first_word_of = `BASE_OLD_LOW + prod[15:0];
    end else begin
      prod = 32'(u - {12'h000, `UNIT_HIGH_FIRST}) * 32'(`WORDS_PER_UNIT);
      first_word_of = `BASE_OLD_HIGH + prod[15:0];
    end
  endfunction

  // unit numbers the controller cannot map in this setting
  function automatic logic unit_refused(input slave_err_pkg::cfg_t c);
    unit_refused = (c.fam == slave_err_pkg::FAM_OLD) && c.mode32 &&
                   ((c.unit == `UNIT_BAD_A) || (c.unit == `UNIT_BAD_B));
  endfunction

  // pack one status word: error byte over active byte
  function automatic logic [15:0] status_word(input logic [7:0] err,
                                              input logic [7:0] act);
    logic [15:0] w;
    w = `STATUS_RESET;
    w[`ERR_MSB:`ERR_LSB] = err;
    w[`ACT_MSB:`ACT_LSB] = act;
    status_word = w;
  endfunction

  // first flagged slave: outputs before inputs, low node first
  function automatic slave_err_pkg::pick_t first_err(input slave_err_pkg::slave_vec_t e);
    slave_err_pkg::pick_t p;
    p = '0;
    for (int i = 15; i >= 0; i--) begin
      if (e.ins[i]) begin
        p.found = 1'b1;
        p.dir   = 1'b0;
        p.node  = 4'(i);
      end
    end
    for (int i = 15; i >= 0; i--) begin
      if (e.outs[i]) begin
        p.found = 1'b1;
        p.dir   = 1'b1;
        p.node  = 4'(i);
      end
    end
    first_err = p;
  endfunction

  // one bit of a slave vector chosen by direction and node
  function automatic logic bit_at(input slave_err_pkg::slave_vec_t v,
                                  input logic dir,
                                  input logic [3:0] node);
    bit_at = dir ? v.outs[node] : v.ins[node];
  endfunction

  // events for nodes beyond the configured range are ignored
  assign mask         = i_cfg.mode32 ? `MASK_32 : `MASK_16;
  assign join_m       = {i_join.outs & mask, i_join.ins & mask};
  assign fail_m       = {i_fail.outs & mask, i_fail.ins & mask};
  assign ok_m         = {i_ok.outs & mask, i_ok.ins & mask};
  // a slave that recovers in this cycle is no longer a display candidate
  assign live_err     = st_q.err & ~ok_m;
  assign pick         = first_err(live_err);
  assign release_disp = st_q.disp_v &&
                        bit_at(ok_m, st_q.disp_dir, st_q.disp_node) &&
                        !bit_at(fail_m, st_q.disp_dir, st_q.disp_node);
  assign ofs          = i_rd_addr - st_q.first_word;

  // next state of flags, display latch and read port
  always_comb begin
    st_d = st_q;
    // a slave joining sets its active flag until a restart or reset
    st_d.act = st_q.act | join_m;
    // failure sets, recovery clears; a coincident failure wins
    st_d.err = (st_q.err & ~ok_m) | fail_m;
    // latch holds one node until that slave recovers
    if (release_disp) begin
      st_d.disp_v = 1'b0;
    end else if (!st_q.disp_v && pick.found) begin
      st_d.disp_v    = 1'b1;
      st_d.disp_dir  = pick.dir;
      st_d.disp_node = pick.node;
    end
    st_d.first_word = first_word_of(i_cfg);
    st_d.unit_bad   = unit_refused(i_cfg);
    // read decode; words outside the area answer zero with no hit
    st_d.rd_hit  = 1'b0;
    st_d.rd_data = `STATUS_RESET;
    if (i_rd_en && !st_q.unit_bad) begin
      if (!i_cfg.mode32) begin
        if (ofs == `OFS_OUT_16) begin
          st_d.rd_hit  = 1'b1;
          st_d.rd_data = status_word(st_q.err.outs[7:0], st_q.act.outs[7:0]);
        end else if (ofs == `OFS_IN_16) begin
          st_d.rd_hit  = 1'b1;
          st_d.rd_data = status_word(st_q.err.ins[7:0], st_q.act.ins[7:0]);
        end
      end else begin
        unique case (ofs)
          `OFS_OUT_LO_32: begin
            st_d.rd_hit  = 1'b1;
            st_d.rd_data = status_word(st_q.err.outs[7:0], st_q.act.outs[7:0]);
          end
          `OFS_IN_LO_32: begin
            st_d.rd_hit  = 1'b1;
            st_d.rd_data = status_word(st_q.err.ins[7:0], st_q.act.ins[7:0]);
          end
          `OFS_OUT_HI_32: begin
            st_d.rd_hit  = 1'b1;
            st_d.rd_data = status_word(st_q.err.outs[15:8], st_q.act.outs[15:8]);
          end
          `OFS_IN_HI_32: begin
            st_d.rd_hit  = 1'b1;
            st_d.rd_data = status_word(st_q.err.ins[15:8], st_q.act.ins[15:8]);
          end
          default: begin
            st_d.rd_hit  = 1'b0;
          end
        endcase
      end
    end
    // restart wipes flags and display but keeps the placement
    if (i_restart) begin
      st_d.act    = '0;
      st_d.err    = '0;
      st_d.disp_v = 1'b0;
    end
  end

  // single state register; reset clears every flag
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // indicators are dark whenever nothing is latched
  assign o_comm_error_indicator = st_q.disp_v;
  assign o_dir_indicator        = st_q.disp_v & st_q.disp_dir;
  assign o_node_ind             = st_q.disp_v ? st_q.disp_node : 4'h0;
  assign o_rd_data              = st_q.rd_data;
  assign o_rd_hit               = st_q.rd_hit;
  assign o_first_word           = st_q.first_word;
  assign o_unit_bad             = st_q.unit_bad;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // helper: flag of the displayed slave
  logic disp_flag;
  assign disp_flag = bit_at(st_q.err, st_q.disp_dir, st_q.disp_node);

  // output node 0 fails on a quiet network, nothing disturbs the next cycle
  sequence s_fail_seen;
    i_fail.outs[0] && !i_restart && !o_comm_error_indicator && !(|st_q.err)
      ##1 (!i_restart && !i_ok.outs[0]);
  endsequence

  // output node 0 is on the indicators
  sequence s_lit_next;
    o_comm_error_indicator && o_dir_indicator && (o_node_ind == 4'h0);
  endsequence

  chk_ind_has_flag: assert property (
    o_comm_error_indicator |-> disp_flag)
    else $error("indicator lit without matching error flag");

  chk_node_weights: assert property (
    o_comm_error_indicator |-> o_node_ind == st_q.disp_node)
    else $error("node indicators differ from latched node");

  chk_dir_matches: assert property (
    o_comm_error_indicator |-> (o_dir_indicator == st_q.disp_dir))
    else $error("direction indicator wrong");

  chk_first_shown: assert property (
    (!o_comm_error_indicator && (|live_err) && !i_restart)
      |=> (o_comm_error_indicator && o_node_ind == $past(pick.node)))
    else $error("pending error not displayed next cycle");

  chk_display_held: assert property (
    (o_comm_error_indicator && !release_disp && !i_restart)
      |=> ($stable(o_node_ind) && $stable(o_dir_indicator)))
    else $error("display changed while held");

  chk_release_next: assert property (
    (release_disp && !i_restart &&
     (|(live_err & ~mask_bit(st_q.disp_dir, st_q.disp_node))))
      |=> !o_comm_error_indicator ##1 o_comm_error_indicator)
    else $error("pending error not shown after release");

  // one-hot vector of a single slave; passing arguments keeps assertions on sampled values
  function automatic slave_err_pkg::slave_vec_t mask_bit(input logic       dir,
                                                         input logic [3:0] node);
    slave_err_pkg::slave_vec_t m;
    m = '0;
    if (dir) begin
      m.outs[node] = 1'b1;
    end else begin
      m.ins[node] = 1'b1;
    end
    mask_bit = m;
  endfunction

  chk_fail_to_show: assert property (
    s_fail_seen |=> s_lit_next)
    else $error("first failure not displayed");

  chk_restart_clr: assert property (
    i_restart |=> (st_q.act == '0 && st_q.err == '0 && !o_comm_error_indicator))
    else $error("restart left flags set");

  chk_active_sticky: assert property (
    (st_q.act.ins[3] && !i_restart) |=> st_q.act.ins[3])
    else $error("active flag dropped");

  chk_ok_clears: assert property (
    (release_disp && !i_restart) |=> (!o_comm_error_indicator && !disp_flag))
    else $error("recovered slave still displayed");

  chk_new_base: assert property (
    (i_rst_n && i_cfg.fam == slave_err_pkg::FAM_NEW && $stable(i_cfg))
      |=> o_first_word == 16'(`BASE_NEW + 16'($past(i_cfg.unit)) * `WORDS_PER_UNIT))
    else $error("new family base wrong");

  chk_unit_refused: assert property (
    (i_rst_n && i_cfg.fam == slave_err_pkg::FAM_OLD && i_cfg.mode32 &&
     i_cfg.unit == `UNIT_BAD_A)
      |=> (o_unit_bad ##1 !o_rd_hit))
    else $error("refused unit accepted");

  chk_read_in16: assert property (
    (i_rd_en && !o_unit_bad && !i_cfg.mode32 && (i_rd_addr == o_first_word + `OFS_IN_16))
      |=> o_rd_hit)
    else $error("input status word not answered in sixteen setting");

  chk_read_hi32: assert property (
    (i_rd_en && !o_unit_bad && i_cfg.mode32 && (i_rd_addr == o_first_word + `OFS_IN_HI_32))
      |=> (o_rd_hit && o_rd_data[`ACT_MSB:`ACT_LSB] == $past(st_q.act.ins[15:8])))
    else $error("upper input status word wrong");

endmodule

// ### tb/slave_net_model.sv
`timescale 1ns/1ps
// network slaves: each send raises one event vector for a single cycle
module slave_net_model (
  // clock
  input  wire logic                 i_mclk,
  // event pulses toward the master
  output slave_err_pkg::slave_vec_t o_join,
  output slave_err_pkg::slave_vec_t o_fail,
  output slave_err_pkg::slave_vec_t o_ok
);
  // quiet network until the first event
  initial begin
    o_join = '0;
    o_fail = '0;
    o_ok   = '0;
  end

  // kind 0 joins, 1 withdraws on error, 2 resumes; a slave never holds an event
  task automatic send(input int kind, input slave_err_pkg::slave_vec_t v);
    @(posedge i_mclk);
    if (kind == 0)
      o_join <= v;
    else if (kind == 1)
      o_fail <= v;
    else
      o_ok <= v;
    @(posedge i_mclk);
    o_join <= '0;
    o_fail <= '0;
    o_ok   <= '0;
  endtask
endmodule

// ### tb/test_slave_error_node_display.sv
`timescale 1ns/1ps
module test_slave_error_node_display;
  logic                      mclk    = 1'b0;
  logic                      rst_n   = 1'b0;
  slave_err_pkg::cfg_t       cfg     = '0;
  logic                      restart = 1'b0;
  logic                      rd_en   = 1'b0;
  logic [15:0]               rd_addr = 16'h0000;
  logic [15:0]               base    = 16'h0000;
  slave_err_pkg::slave_vec_t join_v, fail_v, ok_v;
  logic [15:0]               rd_data, first_word;
  logic                      rd_hit, unit_bad, err_ind, dir_ind;
  logic [3:0]                node_ind;
  int                        n_mismatch  = 0;
  int                        comparisons = 0;
  // rows: family, mode32, unit, refused, first word
  logic [22:0]               rows [7] = '{{2'b00, 4'h3, 1'b0, 16'h07EE},
    {2'b10, 4'h5, 1'b0, 16'h0096}, {2'b10, 4'hC, 1'b0, 16'h01A4},
    {2'b11, 4'h9, 1'b1, 16'h0000}, {2'b11, 4'hF, 1'b1, 16'h0000},
    {2'b11, 4'hE, 1'b0, 16'h01B8}, {2'b10, 4'h9, 1'b0, 16'h00BE}};
  wire logic [16:0]          shown = {11'h000, err_ind, dir_ind, node_ind};

  always #20 mclk = ~mclk;

  slave_net_model NET (.i_mclk(mclk), .o_join(join_v), .o_fail(fail_v), .o_ok(ok_v));

  slave_error_node_display DUT (.i_mclk(mclk), .i_rst_n(rst_n), .i_cfg(cfg),
    .i_restart(restart), .i_join(join_v), .i_fail(fail_v), .i_ok(ok_v),
    .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_hit(rd_hit),
    .o_first_word(first_word), .o_unit_bad(unit_bad),
    .o_comm_error_indicator(err_ind), .o_dir_indicator(dir_ind), .o_node_ind(node_ind));

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // placement is reloaded from the configuration every cycle; every new setting still gets a full reset
  task automatic restart_all(input slave_err_pkg::cfg_t c);
    @(posedge mclk);
    rst_n <= 1'b0;
    cfg   <= c;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // one-cycle read, answer compared in the cycle after the request
  task automatic rdchk(input logic [15:0] ofs, input logic [16:0] exp);
    @(posedge mclk);
    rd_en   <= 1'b1;
    rd_addr <= base + ofs;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk({rd_hit, rd_data}, exp);
  endtask

  // event plus margin for flag and display to settle
  task automatic ev(input int kind, input slave_err_pkg::slave_vec_t v);
    NET.send(kind, v);
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    foreach (rows[i]) begin
      restart_all(rows[i][22:17]);
      chk({16'h0000, unit_bad}, {16'h0000, rows[i][16]});
      if (!rows[i][16])
        chk({1'b0, first_word}, {1'b0, rows[i][15:0]});
    end
    $display("test placement table done");
    base = 16'h07D0;
    restart_all({2'b01, 4'h0});
    ev(0, {16'h0800, 16'h2008});
    rdchk(16'h0010, 17'h1_0000);
    rdchk(16'h0011, 17'h1_0008);
    rdchk(16'h0012, 17'h1_0008);
    rdchk(16'h0013, 17'h1_0020);
    rdchk(16'h0001, 17'h0_0000);
    chk(shown, 17'h0_0000);
    ev(1, {16'h0000, 16'h0008});
    chk(shown, 17'h0_0023);
    ev(1, {16'h0800, 16'h0000});
    chk(shown, 17'h0_0023);
    rdchk(16'h0012, 17'h1_0808);
    ev(2, {16'h0000, 16'h0008});
    chk(shown, 17'h0_003B);
    rdchk(16'h0011, 17'h1_0008);
    ev(2, {16'h0800, 16'h0000});
    chk(shown, 17'h0_0000);
    ev(1, {16'h0040, 16'h2000});
    chk(shown, 17'h0_0036);
    ev(2, {16'h0040, 16'h0000});
    chk(shown, 17'h0_002D);
    $display("test display order done");
    @(posedge mclk);
    restart <= 1'b1;
    @(posedge mclk);
    restart <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(shown, 17'h0_0000);
    rdchk(16'h0013, 17'h1_0000);
    ev(1, {16'h0001, 16'h0000});
    chk(shown, 17'h0_0030);
    rdchk(16'h0010, 17'h1_0100);
    $display("test restart done");
    base = 16'h01A4;
    restart_all({2'b10, 4'hC});
    ev(0, {16'h0200, 16'h0201});
    rdchk(16'h0009, 17'h1_0001);
    rdchk(16'h0000, 17'h1_0000);
    rdchk(16'h0010, 17'h0_0000);
    ev(1, {16'h0000, 16'h0200});
    chk(shown, 17'h0_0000);
    $display("test sixteen setting done");
    base = 16'h00BE;
    restart_all({2'b11, 4'h9});
    rdchk(16'h0011, 17'h0_0000);
    $display("test refused unit done");
    results();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    results();
  end
endmodule
